/* File: include/i2ccp_pkg.sv */
// Purpose: Shared constants of the two-wire control register port.
// Assumes: Seven-bit slave addressing, 24-bit register address and data.
// Notes: The rule summary below is kept next to the constants.
//
// Behaviour
// - Two independent multi-master two-wire ports.
// - Control port acts only as slave target.
// - Slave address configurable, typically 0xB2.
// - Address: space in 23:16, offset 15:0.
// - Read/write bit alone selects direction.
// - Device returns three data bytes, MSB first.
// - Device acks every byte written to it; the code nacks any register byte after the sixth.
// - Exactly one timing master among linked devices.
package i2ccp_pkg;
  // 0xB2 as an eight-bit address byte is 0x59 in seven-bit form.
  localparam logic [6:0] I2CCP_ADDR_RESET = 7'h59;
  localparam logic [3:0] I2CCP_BYTE_BITS = 4'h8;
  localparam logic [2:0] I2CCP_IDX_ADDR_LAST = 3'h2;
  localparam logic [2:0] I2CCP_IDX_DATA_LAST = 3'h5;
  localparam logic [2:0] I2CCP_IDX_FULL = 3'h6;
  localparam int I2CCP_SPACE_MSB = 23;
  localparam int I2CCP_SPACE_LSB = 16;
  localparam int I2CCP_OFFSET_MSB = 15;
  localparam logic [23:0] I2CCP_IDLE_DATA = 24'hFF_FFFF;
  localparam logic [23:0] I2CCP_WORD_RESET = 24'h00_0000;
endpackage : i2ccp_pkg

/* File: src/i2ccp_sync.sv */
// Purpose: Two-flop synchroniser for levels entering a clock domain.
// Assumes: Multi-bit inputs are quasi-static while they matter.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/1ps
module i2ccp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule : i2ccp_sync

/* File: src/i2ccp_cond.sv */
// Purpose: Finds start, stop and clock edges on the synchronised bus lines.
// Assumes: Inputs already passed two flip-flops in the link domain.
// Notes: Both lines idle high, so the history resets to one.
`timescale 1ns/1ps
module i2ccp_cond (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic start_out,
  output logic stop_out,
  output logic rise_out,
  output logic fall_out
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // bus-wide conditions: seen whoever is master, so other masters pass.
  assign start_out = scl_q & scl_in & sda_q & ~sda_in;
  assign stop_out = scl_q & scl_in & ~sda_q & sda_in;
  assign rise_out = ~scl_q & scl_in;
  assign fall_out = scl_q & ~scl_in;
endmodule : i2ccp_cond

/* File: src/i2ccp_port.sv */
// Purpose: Two-wire slave port giving a host access to 24-bit registers.
// Assumes: Link clock samples the bus at least eight times per bus bit.
// Notes: Register requests cross to the system clock by toggle handshake.
`timescale 1ns/1ps
module i2ccp_port
  import i2ccp_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic CLK_LINK_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic [6:0] SLAVE_ADDR_IN,
  input wire logic TIMING_MASTER_IN,
  output logic TIMING_MASTER_OUT,
  output logic WR_STB_OUT,
  output logic RD_STB_OUT,
  output logic [7:0] SPACE_OUT,
  output logic [15:0] OFFSET_OUT,
  output logic [23:0] WDATA_OUT,
  input wire logic [23:0] RDATA_IN,
  input wire logic RD_ACK_IN,
  output logic BUSY_OUT
);
  typedef enum logic [2:0] {
    LK_IDLE, LK_RX, LK_ACK, LK_TX, LK_HACK, LK_IGNORE
  } i2ccp_link_type;

  // Link-domain state.
  i2ccp_link_type state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [2:0] idx_q, idx_d;
  logic first_q, first_d;
  logic rw_q, rw_d;
  logic [23:0] addr_q, addr_d;
  logic [23:0] wdata_q, wdata_d;
  logic [23:0] tx_q, tx_d;
  logic oe_q, oe_d;
  logic req_tgl_q, req_tgl_d;
  logic rtype_q, rtype_d;
  logic [6:0] saddr_q, saddr_d;
  logic [23:0] rdata_q, rdata_d;
  logic rdv_q, rdv_d;
  logic ack_prev_q, ack_prev_d;

  // System-domain state.
  logic req_prev_q, req_prev_d;
  logic wr_stb_q, wr_stb_d;
  logic rd_stb_q, rd_stb_d;
  logic [23:0] out_addr_q, out_addr_d;
  logic [23:0] out_wdata_q, out_wdata_d;
  logic [23:0] rdata_hold_q, rdata_hold_d;
  logic ack_tgl_q, ack_tgl_d;
  logic pend_q, pend_d;
  logic strap_done_q, strap_done_d;
  logic master_q, master_d;
  logic [1:0] settle_q, settle_d;

  logic scl_s, sda_s, ack_s, req_s, strap_s, busy_s;
  logic [6:0] saddr_s;
  logic start, stop, rise, fall;

  i2ccp_sync #(.W(2), .INIT(2'b11)) u_pin_sync (
    .clk_in(CLK_LINK_IN),
    .rst_in(RST_IN),
    .d_in({SCL_IN, SDA_IN}),
    .q_out({scl_s, sda_s})
  );

  // The address is static once configured, so a plain level sync suffices.
  i2ccp_sync #(.W(8), .INIT({I2CCP_ADDR_RESET, 1'b0})) u_cfg_sync (
    .clk_in(CLK_LINK_IN),
    .rst_in(RST_IN),
    .d_in({SLAVE_ADDR_IN, ack_tgl_q}),
    .q_out({saddr_s, ack_s})
  );

  i2ccp_sync #(.W(3)) u_sys_sync (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .d_in({req_tgl_q, TIMING_MASTER_IN, state_q != LK_IDLE}),
    .q_out({req_s, strap_s, busy_s})
  );

  i2ccp_cond u_cond (
    .clk_in(CLK_LINK_IN),
    .rst_in(RST_IN),
    .scl_in(scl_s),
    .sda_in(sda_s),
    .start_out(start),
    .stop_out(stop),
    .rise_out(rise),
    .fall_out(fall)
  );

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    idx_d = idx_q;
    first_d = first_q;
    rw_d = rw_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    tx_d = tx_q;
    oe_d = oe_q;
    req_tgl_d = req_tgl_q;
    rtype_d = rtype_q;
    saddr_d = saddr_q;
    rdata_d = rdata_q;
    rdv_d = rdv_q;
    ack_prev_d = ack_s;
    if (ack_s != ack_prev_q) begin
      rdata_d = rdata_hold_q;
      rdv_d = 1'b1;
    end
    // resync on any start: a repeated start or another master's frame.
    if (start) begin
      state_d = LK_RX;
      cnt_d = 4'h0;
      first_d = 1'b1;
      oe_d = 1'b0;
    end else if (stop) begin
      state_d = LK_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (state_q)
        LK_IDLE: begin
          saddr_d = saddr_s;
        end
        LK_RX: begin
          if (rise) begin
            shift_d = {shift_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == I2CCP_BYTE_BITS) begin
            cnt_d = 4'h0;
            first_d = 1'b0;
            state_d = LK_ACK;
            oe_d = 1'b1;
            if (first_q) begin
              if (shift_q[7:1] != saddr_q) begin
                state_d = LK_IGNORE;
                oe_d = 1'b0;
              end else begin
                rw_d = shift_q[0];
                if (shift_q[0]) begin
                  tx_d = rdv_q ? rdata_q : I2CCP_IDLE_DATA;
                end else begin
                  idx_d = 3'h0;
                end
              end
            end else if (idx_q == I2CCP_IDX_FULL) begin
              state_d = LK_IGNORE;
              oe_d = 1'b0;
            end else begin
              idx_d = idx_q + 3'h1;
              if (idx_q <= I2CCP_IDX_ADDR_LAST) begin
                addr_d = {addr_q[15:0], shift_q};
              end else begin
                wdata_d = {wdata_q[15:0], shift_q};
              end
              if (idx_q == I2CCP_IDX_ADDR_LAST) begin
                req_tgl_d = ~req_tgl_q;
                rtype_d = 1'b1;
                rdv_d = 1'b0;
              end
              if (idx_q == I2CCP_IDX_DATA_LAST) begin
                req_tgl_d = ~req_tgl_q;
                rtype_d = 1'b0;
              end
            end
          end
        end
        LK_ACK: begin
          if (fall) begin
            if (rw_q) begin
              oe_d = ~tx_q[23];
              tx_d = {tx_q[22:0], 1'b1};
              cnt_d = 4'h1;
              state_d = LK_TX;
            end else begin
              oe_d = 1'b0;
              state_d = LK_RX;
            end
          end
        end
        LK_TX: begin
          if (fall) begin
            if (cnt_q == I2CCP_BYTE_BITS) begin
              oe_d = 1'b0;
              cnt_d = 4'h0;
              state_d = LK_HACK;
            end else begin
              oe_d = ~tx_q[23];
              tx_d = {tx_q[22:0], 1'b1};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        LK_HACK: begin
          if (rise && sda_s) begin
            state_d = LK_IGNORE;
          end else if (fall) begin
            oe_d = ~tx_q[23];
            tx_d = {tx_q[22:0], 1'b1};
            cnt_d = 4'h1;
            state_d = LK_TX;
          end
        end
        LK_IGNORE: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_LINK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_q <= LK_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      idx_q <= 3'h0;
      first_q <= 1'b0;
      rw_q <= 1'b0;
      addr_q <= I2CCP_WORD_RESET;
      wdata_q <= I2CCP_WORD_RESET;
      tx_q <= I2CCP_IDLE_DATA;
      oe_q <= 1'b0;
      req_tgl_q <= 1'b0;
      rtype_q <= 1'b0;
      saddr_q <= I2CCP_ADDR_RESET;
      rdata_q <= I2CCP_WORD_RESET;
      rdv_q <= 1'b0;
      ack_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      idx_q <= idx_d;
      first_q <= first_d;
      rw_q <= rw_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      tx_q <= tx_d;
      oe_q <= oe_d;
      req_tgl_q <= req_tgl_d;
      rtype_q <= rtype_d;
      saddr_q <= saddr_d;
      rdata_q <= rdata_d;
      rdv_q <= rdv_d;
      ack_prev_q <= ack_prev_d;
    end
  end

  // Link words are held stable for many bus bits after a toggle, so the
  // system side may sample them once the synchronised toggle moves.
  always_comb begin
    req_prev_d = req_s;
    wr_stb_d = 1'b0;
    rd_stb_d = 1'b0;
    out_addr_d = out_addr_q;
    out_wdata_d = out_wdata_q;
    rdata_hold_d = rdata_hold_q;
    ack_tgl_d = ack_tgl_q;
    pend_d = pend_q;
    strap_done_d = strap_done_q | (settle_q == 2'h3);
    settle_d = settle_q;
    master_d = master_q;
    if (req_s != req_prev_q) begin
      out_addr_d = addr_q;
      out_wdata_d = wdata_q;
      wr_stb_d = ~rtype_q;
      rd_stb_d = rtype_q;
      pend_d = rtype_q;
    end else if (pend_q && RD_ACK_IN) begin
      rdata_hold_d = RDATA_IN;
      ack_tgl_d = ~ack_tgl_q;
      pend_d = 1'b0;
    end
    // role strap caught once.
    // The strap is taken only after its synchroniser has filled, since
    // the first two stages still hold their reset value.
    if (!strap_done_q) begin
      master_d = strap_s;
      settle_d = settle_q + 2'h1;
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      req_prev_q <= 1'b0;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      out_addr_q <= I2CCP_WORD_RESET;
      out_wdata_q <= I2CCP_WORD_RESET;
      rdata_hold_q <= I2CCP_WORD_RESET;
      ack_tgl_q <= 1'b0;
      pend_q <= 1'b0;
      strap_done_q <= 1'b0;
      master_q <= 1'b0;
      settle_q <= 2'h0;
    end else begin
      req_prev_q <= req_prev_d;
      wr_stb_q <= wr_stb_d;
      rd_stb_q <= rd_stb_d;
      out_addr_q <= out_addr_d;
      out_wdata_q <= out_wdata_d;
      rdata_hold_q <= rdata_hold_d;
      ack_tgl_q <= ack_tgl_d;
      pend_q <= pend_d;
      strap_done_q <= strap_done_d;
      master_q <= master_d;
      settle_q <= settle_d;
    end
  end

  // slave only: the clock line is never driven, data only pulled low.
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = oe_q;
  assign WR_STB_OUT = wr_stb_q;
  assign RD_STB_OUT = rd_stb_q;
  assign SPACE_OUT = out_addr_q[I2CCP_SPACE_MSB:I2CCP_SPACE_LSB];
  assign OFFSET_OUT = out_addr_q[I2CCP_OFFSET_MSB:0];
  assign WDATA_OUT = out_wdata_q;
  assign TIMING_MASTER_OUT = master_q;
  assign BUSY_OUT = busy_s;
endmodule : i2ccp_port

/* File: bench/i2ccp_port_chk.sv */
// Purpose: Concurrent checks on the ports of the control register port.
// Assumes: The bench keeps the timing strap static after reset.
// Notes: Link checks take the link clock as their cause and read the raw bus clock.
`timescale 1ns/1ps
module i2ccp_port_chk (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic CLK_LINK_IN,
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT,
  input wire logic TIMING_MASTER_OUT,
  input wire logic WR_STB_OUT,
  input wire logic RD_STB_OUT,
  input wire logic [7:0] SPACE_OUT,
  input wire logic [15:0] OFFSET_OUT,
  input wire logic [23:0] WDATA_OUT,
  input wire logic BUSY_OUT
);
  logic [3:0] age_q;
  logic [3:0] age_d;
  always_comb begin
    age_d = age_q;
    if (age_q != 4'hF) begin
      age_d = age_q + 4'h1;
    end
  end
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      age_q <= 4'h0;
    end else begin
      age_q <= age_d;
    end
  end
  a_wr_one_cycle: assert property (
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    WR_STB_OUT |=> !WR_STB_OUT && !RD_STB_OUT) else $error("write strobe");
  a_rd_one_cycle: assert property (
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    RD_STB_OUT |=> !RD_STB_OUT && !WR_STB_OUT) else $error("read strobe");
  a_regs_hold: assert property (
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    !WR_STB_OUT && !RD_STB_OUT |-> $stable({SPACE_OUT, OFFSET_OUT, WDATA_OUT}))
    else $error("request fields moved");
  a_busy_strobe: assert property (
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    WR_STB_OUT || RD_STB_OUT |-> BUSY_OUT) else $error("strobe while idle");
  a_role_fixed: assert property (
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    age_q == 4'hF |-> $stable(TIMING_MASTER_OUT)) else $error("role moved");
  a_sda_drive_low: assert property (
    @(posedge CLK_LINK_IN) disable iff (RST_IN)
    SDA_OUT == 1'b0) else $error("data pin driven high");
  a_oe_scl_low: assert property (
    @(posedge CLK_LINK_IN) disable iff (RST_IN)
    $changed(SDA_OE_OUT) |-> !SCL_IN) else $error("data moved in clock high");
  a_oe_held: assert property (
    @(posedge CLK_LINK_IN) disable iff (RST_IN)
    $rose(SDA_OE_OUT) |-> SDA_OE_OUT [*8]) else $error("pull-down too short");
  c_write: cover property (@(posedge CLK_SYS_IN) WR_STB_OUT);
  c_read: cover property (@(posedge CLK_SYS_IN) RD_STB_OUT);
  c_ack: cover property (@(posedge CLK_LINK_IN) $rose(SDA_OE_OUT));
endmodule : i2ccp_port_chk

bind i2ccp_port i2ccp_port_chk i_chk (
  .CLK_SYS_IN(CLK_SYS_IN),
  .RST_IN(RST_IN),
  .CLK_LINK_IN(CLK_LINK_IN),
  .SCL_IN(SCL_IN),
  .SDA_OUT(SDA_OUT),
  .SDA_OE_OUT(SDA_OE_OUT),
  .TIMING_MASTER_OUT(TIMING_MASTER_OUT),
  .WR_STB_OUT(WR_STB_OUT),
  .RD_STB_OUT(RD_STB_OUT),
  .SPACE_OUT(SPACE_OUT),
  .OFFSET_OUT(OFFSET_OUT),
  .WDATA_OUT(WDATA_OUT),
  .BUSY_OUT(BUSY_OUT)
);

/* File: bench/i2ccp_host.sv */
// Purpose: Behavioural host that masters the two-wire bus.
// Assumes: Both lines have pull-ups, so a released line reads high.
// Notes: Phases last ten link cycles, above the minimum of eight.
`timescale 1ns/1ps
module i2ccp_host (
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  localparam time PHASE = 640ns;
  logic hold_low = 1'b0;
  assign sda_out = !(hold_low || sda_oe_in);
  initial begin
    scl_out = 1'b1;
  end
  task automatic start();
    hold_low = 1'b0;
    #PHASE scl_out = 1'b1;
    #PHASE hold_low = 1'b1;
    #PHASE scl_out = 1'b0;
  endtask : start
  task automatic stop();
    hold_low = 1'b1;
    #PHASE scl_out = 1'b1;
    #PHASE hold_low = 1'b0;
    #PHASE;
  endtask : stop
  // Nine bits, MSB first; a released bit lets the device answer.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      hold_low = !tx[i];
      #PHASE scl_out = 1'b1;
      #(PHASE / 2) rx[i] = sda_out;
      #(PHASE / 2) scl_out = 1'b0;
    end
  endtask : xfer
endmodule : i2ccp_host

/* File: bench/i2c_control_register_port_test.sv */
// Purpose: Self-checking bench for the control register port.
// Assumes: The slave address stays at its reset value.
// Notes: Read data is derived from the address so a stale latch shows.
`timescale 1ns/1ps
module i2c_control_register_port_test;
  import i2ccp_pkg::*;
  logic clk_sys, rst, clk_link, strap, rd_ack;
  logic [6:0] slave_addr;
  logic [23:0] rdata, wr_word, wr_where;
  logic [8:0] rx;
  int miscompares = 0;
  int cmp_count = 0;
  int wr_cnt = 0;
  wire scl, sda, oe, wr, rd, tm, busy;
  wire [7:0] space;
  wire [15:0] offset;
  wire [23:0] wdata;
  i2ccp_port i_dut (.CLK_SYS_IN(clk_sys), .RST_IN(rst),
    .CLK_LINK_IN(clk_link), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(),
    .SDA_OE_OUT(oe), .SLAVE_ADDR_IN(slave_addr), .TIMING_MASTER_IN(strap),
    .TIMING_MASTER_OUT(tm), .WR_STB_OUT(wr), .RD_STB_OUT(rd),
    .SPACE_OUT(space), .OFFSET_OUT(offset), .WDATA_OUT(wdata),
    .RDATA_IN(rdata), .RD_ACK_IN(rd_ack), .BUSY_OUT(busy));
  i2ccp_host i_host (.sda_oe_in(oe), .scl_out(scl), .sda_out(sda));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #3;
    forever begin
      clk_link = ~clk_link;
      #32;
    end
  end
  // Answer each read request a few cycles late.
  // Strobes are looked at on the falling edge, where they have settled.
  always @(negedge clk_sys) begin
    if (rd === 1'b1) begin
      repeat (3) @(posedge clk_sys);
      #1 rdata = {space ^ 8'hA5, offset};
      rd_ack = 1'b1;
      @(posedge clk_sys);
      #1 rd_ack = 1'b0;
    end
  end
  always @(negedge clk_sys) begin
    if (wr === 1'b1) begin
      wr_cnt++;
      wr_word = wdata;
      wr_where = {space, offset};
    end
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic send(input logic [7:0] b, input logic nack);
    i_host.xfer({b, 1'b1}, rx);
    check({23'h00_0000, rx[0]}, {23'h00_0000, nack});
  endtask : send
  task automatic wait_idle();
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk_sys);
    check({23'h00_0000, busy}, 24'h00_0000);
  endtask : wait_idle
  task automatic t_write();
    logic [7:0] f [7] = '{8'hB2, 8'h01, 8'h23, 8'h45, 8'hAA, 8'hBB, 8'hCC};
    i_host.start();
    foreach (f[i]) send(f[i], 1'b0);
    i_host.stop();
    wait_idle();
    check(wr_cnt[23:0], 24'h00_0001);
    check(wr_where, 24'h01_2345);
    check(wr_word, 24'hAA_BBCC);
  endtask : t_write
  task automatic t_read();
    logic [23:0] exp;
    exp = {8'h7F ^ 8'hA5, 16'h0010};
    i_host.start();
    send(8'hB2, 1'b0);
    send(8'h7F, 1'b0);
    send(8'h00, 1'b0);
    send(8'h10, 1'b0);
    i_host.start();
    send(8'hB3, 1'b0);
    for (int i = 0; i < 3; i++) begin
      i_host.xfer({8'hFF, i == 2}, rx);
      check({16'h0000, rx[8:1]}, {16'h0000, exp[23 - 8 * i -: 8]});
    end
    i_host.stop();
    wait_idle();
    check(wr_cnt[23:0], 24'h00_0001);
  endtask : t_read
  task automatic t_nomatch();
    i_host.start();
    send(8'hB4, 1'b1);
    i_host.stop();
    wait_idle();
    check(wr_cnt[23:0], 24'h00_0001);
  endtask : t_nomatch
  task automatic t_reset();
    @(posedge clk_sys);
    #1 rst = 1'b1;
    strap = 1'b0;
    repeat (8) @(posedge clk_sys);
    check({22'h00_0000, oe, busy}, 24'h00_0000);
    #1 rst = 1'b0;
    repeat (20) @(posedge clk_sys);
    check({23'h00_0000, tm}, 24'h00_0000);
    i_host.start();
    send(8'hB2, 1'b0);
    i_host.stop();
    wait_idle();
  endtask : t_reset
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  initial begin
    rst = 1'b1;
    strap = 1'b1;
    rd_ack = 1'b0;
    rdata = 24'h00_0000;
    slave_addr = I2CCP_ADDR_RESET;
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (20) @(posedge clk_sys);
    check({23'h00_0000, tm}, {23'h00_0000, strap});
    t_write();
    t_read();
    t_nomatch();
    t_reset();
    summarize();
  end
  initial begin
    #500us;
    miscompares++;
    summarize();
  end
endmodule : i2c_control_register_port_test
